// >>> shared/cpi_pkg.sv
// Constants, types and carriers of the cyclic process-data image bank.
// Assumes one core clock domain; all importers share these layouts.
//
// What this block does
// - Status word: ready, pass, read, latch, outputs, missed
// - Inspection image: status word then seven 32-bit values
// - Inspection image always present, never removable
// - Acknowledge word bits 0-3, errors 13-15, error code
// - Control image removable; absent means no exchange
// - Single barcode image field order fixed
// - Single barcode string of 16 to 512 bytes
// - Barcode images are input-only, writes refused
// - Multiple barcode image holds ten records
// - Only 16-byte variant has 32-bit actual length
// - Command channel capacities 0, 32, 64, 128 bytes
// - Command image subslot 1, response subslot 2
`default_nettype none

package cpi_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Image addressing
    localparam int unsigned CPI_OFS_W      = 10;
    localparam logic [2:0]  CPI_SLOT_CTRL  = 3'h1;
    localparam logic [2:0]  CPI_SLOT_SENS  = 3'h2;
    localparam logic [2:0]  CPI_SLOT_CMDCH = 3'h4;
    localparam logic [1:0]  CPI_SUB_1      = 2'h1;
    localparam logic [1:0]  CPI_SUB_2      = 2'h2;

    // Image lengths and layout offsets in bytes
    localparam logic [9:0]  CPI_INSP_LEN   = 10'h01e;
    localparam logic [9:0]  CPI_STAT_LEN   = 10'h002;
    localparam logic [9:0]  CPI_CTRL_LEN   = 10'h006;
    localparam logic [9:0]  CPI_HDR_SMALL  = 10'h012;
    localparam logic [9:0]  CPI_HDR_LARGE  = 10'h010;
    localparam logic [9:0]  CPI_MB_HDR     = 10'h008;
    localparam logic [9:0]  CPI_MB_REC     = 10'h028;
    localparam logic [9:0]  CPI_MB_RECHDR  = 10'h008;
    localparam logic [9:0]  CPI_MB_LEN     = 10'h198;
    localparam logic [9:0]  CPI_STR_MIN    = 10'h010;
    localparam int unsigned CPI_MB_NREC    = 10;
    localparam int unsigned CPI_MB_STR     = 32;
    localparam int unsigned CPI_STR_MAX    = 512;

    // Command channel string capacities
    localparam logic [9:0]  CPI_CC_CAP32   = 10'h020;
    localparam logic [9:0]  CPI_CC_CAP64   = 10'h040;
    localparam logic [9:0]  CPI_CC_CAP128  = 10'h080;

    // Status and acknowledge bit positions
    localparam int unsigned CPI_ST_READY   = 0;
    localparam int unsigned CPI_ST_PASS    = 1;
    localparam int unsigned CPI_ST_READ    = 2;
    localparam int unsigned CPI_ST_LATCH   = 3;
    localparam int unsigned CPI_ST_OUT1    = 4;
    localparam int unsigned CPI_ST_MISSED  = 7;
    localparam int unsigned CPI_ACK_TEACHE = 13;
    localparam int unsigned CPI_NREQ       = 4;

    // Reset values
    localparam logic [15:0] CPI_RST_W16    = 16'h0000;
    localparam logic [31:0] CPI_RST_W32    = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Modes and carriers
    typedef enum logic [2:0] {
        CPI_BC_NONE, CPI_BC_16, CPI_BC_32, CPI_BC_64, CPI_BC_128, CPI_BC_256, CPI_BC_512, CPI_BC_MULTI
    } cpi_bc_e;

    typedef enum logic [1:0] {CPI_CC_0, CPI_CC_32, CPI_CC_64, CPI_CC_128} cpi_cc_e;

    typedef struct packed {
        logic [2:0] slot;
        logic [1:0] sub;
        logic [9:0] offs;
    } cpi_at_s;

    typedef struct packed {
        logic        ready;
        logic        pass;
        logic        read_ok;
        logic        ready_latch;
        logic [2:0]  outs;
        logic        missed_flag;
        logic        done;
        logic        missed;
        logic [31:0] sensor_pf;
        logic [31:0] insp_time;
    } cpi_insp_s;

    typedef struct packed {
        logic [31:0] frame;
        logic [15:0] sensor;
        logic [15:0] count;
    } cpi_bc_hdr_s;

    typedef struct packed {
        logic [15:0] btype;
        logic [31:0] act_len;
        logic [31:0] out_len;
    } cpi_bc_rec_s;

endpackage

`default_nettype wire

// >>> logic/cpi_req_ack.sv
// Per-bit request/acknowledge handshake for the device-control requests.
// Assumes requests are stable levels on the core clock.
`default_nettype none

module cpi_req_ack #(
    parameter int unsigned N = 4
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Control image present
    input  wire logic         en,
    // Request levels and completion pulses
    input  wire logic [N-1:0] req,
    input  wire logic [N-1:0] done,
    // Action start pulses and acknowledge levels
    output var  logic [N-1:0] start,
    output var  logic [N-1:0] ack
);
    import cpi_pkg::*;

    typedef enum logic [1:0] {CPI_HS_IDLE, CPI_HS_BUSY, CPI_HS_ACKED} cpi_hs_e;

    ////////////////////////////////////////////////////////////////////////
    // One small machine per request bit
    for (genvar i = 0; i < N; i++) begin : g_bit
        cpi_hs_e st;
        cpi_hs_e next_st;

        // A request held high never re-fires; it must drop first
        always_comb begin
            next_st = st;
            unique case (st)
                CPI_HS_IDLE:  if (req[i]) next_st = CPI_HS_BUSY;
                CPI_HS_BUSY:  if (done[i]) next_st = CPI_HS_ACKED;
                CPI_HS_ACKED: if (!req[i]) next_st = CPI_HS_IDLE;
            endcase
            if (!en) next_st = CPI_HS_IDLE;
        end

        // State, start pulse and acknowledge all registered
        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                st       <= CPI_HS_IDLE;
                start[i] <= 1'b0;
                ack[i]   <= 1'b0;
            end else begin
                st       <= next_st;
                start[i] <= (st == CPI_HS_IDLE) && (next_st == CPI_HS_BUSY);
                ack[i]   <= (next_st == CPI_HS_ACKED);
            end
        end
    end

endmodule

`default_nettype wire

// >>> logic/cpi_bank.sv
// Cyclic process-data image bank: inspection result, device control,
// barcode output and command channel images, read and written bytewise.
// Assumes the controller port and the application run on core_clk.
`default_nettype none

module cpi_bank (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_b,
    // Image configuration
    input  wire logic                 ctrl_img_en,
    input  wire cpi_pkg::cpi_bc_e     bc_sel,
    input  wire cpi_pkg::cpi_cc_e     cmd_cap,
    input  wire cpi_pkg::cpi_cc_e     rsp_cap,
    // Controller read port
    input  wire logic                 rd_req,
    input  wire cpi_pkg::cpi_at_s     rd_at,
    output var  logic                 rd_valid,
    output var  logic [7:0]           rd_data,
    output var  logic                 rd_err,
    // Controller write port
    input  wire logic                 wr_req,
    input  wire cpi_pkg::cpi_at_s     wr_at,
    input  wire logic [7:0]           wr_data,
    output var  logic                 wr_ack,
    output var  logic                 wr_err,
    // Application inspection status
    input  wire cpi_pkg::cpi_insp_s   insp,
    // Application actions
    output logic [3:0]                act_start,
    input  wire logic [3:0]           act_done,
    input  wire logic [31:0]          act_err_code,
    input  wire logic [2:0]           act_err_flags,
    output var  logic [31:0]          product_change_number,
    // Barcode loading
    input  wire logic                 bc_hdr_wr,
    input  wire cpi_pkg::cpi_bc_hdr_s bc_hdr,
    input  wire logic                 bc_rec_wr,
    input  wire logic [3:0]           bc_rec_idx,
    input  wire cpi_pkg::cpi_bc_rec_s bc_rec,
    input  wire logic                 bc_str_wr,
    input  wire logic [8:0]           bc_str_addr,
    input  wire logic [7:0]           bc_str_data
);
    import cpi_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    logic [15:0]       inspection_status_word;
    logic [31:0]       insp_word [7];            // Number, pf, iter, pass, fail, missed, time
    logic [15:0]       control_request_word;
    logic [15:0]       control_ack_word;
    logic [31:0]       return_error_code;
    logic [2:0]        err_bits;
    logic [3:0]        ack_lv;
    cpi_bc_hdr_s       bc_hdr_q;
    cpi_bc_rec_s       bc_rec_q [CPI_MB_NREC];
    logic [7:0]        str_mem  [CPI_STR_MAX];

    ////////////////////////////////////////////////////////////////////////
    // Image selection for reads
    wire logic rd_insp = (rd_at.slot == CPI_SLOT_CTRL)  && (rd_at.sub == CPI_SUB_1);
    wire logic rd_ctrl = (rd_at.slot == CPI_SLOT_CTRL)  && (rd_at.sub == CPI_SUB_2);
    wire logic rd_bc   = (rd_at.slot == CPI_SLOT_SENS)  && (rd_at.sub == CPI_SUB_1);
    wire logic rd_ccmd = (rd_at.slot == CPI_SLOT_CMDCH) && (rd_at.sub == CPI_SUB_1);
    wire logic rd_crsp = (rd_at.slot == CPI_SLOT_CMDCH) && (rd_at.sub == CPI_SUB_2);

    // Image selection for writes
    wire logic wr_ctrl = (wr_at.slot == CPI_SLOT_CTRL)  && (wr_at.sub == CPI_SUB_2);
    wire logic wr_ccmd = (wr_at.slot == CPI_SLOT_CMDCH) && (wr_at.sub == CPI_SUB_1);

    // Command channel capacities per part
    function automatic logic [9:0] cc_len(input cpi_cc_e c);
        logic [9:0] n;
        n = 10'h000;
        unique case (c)
            CPI_CC_0:   n = 10'h000;
            CPI_CC_32:  n = CPI_CC_CAP32;
            CPI_CC_64:  n = CPI_CC_CAP64;
            CPI_CC_128: n = CPI_CC_CAP128;
        endcase
        return n;
    endfunction

    wire logic [9:0] ccmd_len = cc_len(cmd_cap);
    wire logic [9:0] crsp_len = cc_len(rsp_cap);

    ////////////////////////////////////////////////////////////////////////
    // Barcode image geometry
    wire logic       bc_multi = (bc_sel == CPI_BC_MULTI);
    wire logic       bc_small = (bc_sel == CPI_BC_16);
    wire logic       bc_on    = (bc_sel != CPI_BC_NONE);
    wire logic [2:0] bc_shift = 3'(bc_sel) - 3'h1;
    wire logic [9:0] bc_cap   = CPI_STR_MIN << bc_shift;
    wire logic [9:0] bc_hlen  = bc_small ? CPI_HDR_SMALL : CPI_HDR_LARGE;
    wire logic [9:0] bc_len   = bc_multi ? CPI_MB_LEN : 10'(bc_hlen + bc_cap);

    // Header for single images; the 16-byte variant widens actual length
    wire logic [143:0] hdr_small = {bc_hdr_q.frame, bc_hdr_q.sensor, bc_hdr_q.count,
                                    bc_rec_q[0].btype, bc_rec_q[0].act_len, bc_rec_q[0].out_len};
    wire logic [143:0] hdr_large = {bc_hdr_q.frame, bc_hdr_q.sensor, bc_hdr_q.count,
                                    bc_rec_q[0].btype, bc_rec_q[0].act_len[15:0], bc_rec_q[0].out_len,
                                    16'h0000};
    wire logic [143:0] hdr_sel   = bc_small ? hdr_small : hdr_large;

    // Multiple image: eight header bytes, then ten records of forty bytes
    wire logic [9:0]  mb_rel  = rd_at.offs - CPI_MB_HDR;
    wire logic [3:0]  mb_rec  = 4'(mb_rel / CPI_MB_REC);
    wire logic [9:0]  mb_in   = mb_rel - 10'(mb_rec * CPI_MB_REC);
    wire logic [63:0] mb_rhdr = {bc_rec_q[mb_rec].btype, bc_rec_q[mb_rec].act_len[15:0],
                                 bc_rec_q[mb_rec].out_len};
    wire logic [8:0]  mb_saddr = 9'(mb_rec * CPI_MB_STR) + 9'(mb_in - CPI_MB_RECHDR);

    // Byte pickers, big-endian as on the network
    wire logic [7:0]  hdr_bi   = 8'(rd_at.offs[4:0]);
    wire logic [7:0]  hdr_byte = hdr_sel[8'(8'd143 - (hdr_bi << 3)) -: 8];
    wire logic [7:0]  mbh_byte = hdr_sel[8'(8'd143 - (hdr_bi << 3)) -: 8];
    wire logic [5:0]  rh_bi    = 6'(mb_in[2:0]);
    wire logic [7:0]  mbr_byte = mb_rhdr[6'(6'd63 - (rh_bi << 3)) -: 8];
    wire logic [8:0]  s_addr   = 9'(rd_at.offs - bc_hlen);
    wire logic [7:0]  sgl_str  = str_mem[s_addr];
    wire logic [7:0]  mb_str   = str_mem[mb_saddr];

    wire logic [7:0]  bc_byte  = bc_multi ?
                                 ((rd_at.offs < CPI_MB_HDR) ? mbh_byte :
                                  (mb_in < CPI_MB_RECHDR) ? mbr_byte : mb_str) :
                                 ((rd_at.offs < bc_hlen) ? hdr_byte : sgl_str);

    ////////////////////////////////////////////////////////////////////////
    // Inspection and control image bytes
    wire logic [9:0]  iw_rel   = rd_at.offs - CPI_STAT_LEN;
    wire logic [2:0]  iw_idx   = iw_rel[4:2];
    wire logic [1:0]  iw_k     = iw_rel[1:0];
    wire logic [31:0] iw_val   = insp_word[iw_idx];
    wire logic [7:0]  iw_byte  = iw_val[5'(5'd31 - {iw_k, 3'b000}) -: 8];
    wire logic [7:0]  st_byte  = rd_at.offs[0] ? inspection_status_word[7:0] : inspection_status_word[15:8];
    wire logic [7:0]  insp_byte = (rd_at.offs < CPI_STAT_LEN) ? st_byte : iw_byte;

    wire logic [47:0] ctrl_in  = {control_ack_word, return_error_code};
    wire logic [7:0]  ctrl_byte = ctrl_in[6'(6'd47 - {rd_at.offs[2:0], 3'b000}) -: 8];

    ////////////////////////////////////////////////////////////////////////
    // Read decode; output images and absent images answer with an error
    wire logic rd_ok_insp = rd_insp && (rd_at.offs < CPI_INSP_LEN);
    wire logic rd_ok_ctrl = rd_ctrl && ctrl_img_en && (rd_at.offs < CPI_CTRL_LEN);
    wire logic rd_ok_bc   = rd_bc && bc_on && (rd_at.offs < bc_len);
    wire logic rd_ok_crsp = rd_crsp && (rd_at.offs < crsp_len);
    wire logic rd_ok      = rd_ok_insp | rd_ok_ctrl | rd_ok_bc | rd_ok_crsp;

    // Response payload is not modelled and reads as zero
    wire logic [7:0] next_rd_data = rd_ok_insp ? insp_byte :
                                    rd_ok_ctrl ? ctrl_byte :
                                    rd_ok_bc   ? bc_byte   : 8'h00;

    // Read answer one cycle after the request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
            rd_err   <= 1'b0;
        end else begin
            rd_valid <= rd_req;
            rd_data  <= (rd_req && rd_ok) ? next_rd_data : 8'h00;
            rd_err   <= rd_req && !rd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write decode; only the control output image and the command part
    // of the command channel take data, barcode images refuse writes
    wire logic wr_ok_ctrl = wr_ctrl && ctrl_img_en && (wr_at.offs < CPI_CTRL_LEN);
    wire logic wr_ok_ccmd = wr_ccmd && (wr_at.offs < ccmd_len);
    wire logic wr_ok      = wr_ok_ctrl | wr_ok_ccmd;
    wire logic wr_take    = wr_req && wr_ok_ctrl;

    // Write answer one cycle after the request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ack <= 1'b0;
            wr_err <= 1'b0;
        end else begin
            wr_ack <= wr_req && wr_ok;
            wr_err <= wr_req && !wr_ok;
        end
    end

    // Command word and product change number, big-endian byte lanes;
    // removing the image drops all requests at once
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            control_request_word  <= CPI_RST_W16;
            product_change_number <= CPI_RST_W32;
        end else if (!ctrl_img_en) begin
            control_request_word  <= CPI_RST_W16;
        end else if (wr_take) begin
            unique case (wr_at.offs[2:0])
                3'h0:    control_request_word[15:8]   <= wr_data;
                3'h1:    control_request_word[7:0]    <= wr_data;
                3'h2:    product_change_number[31:24] <= wr_data;
                3'h3:    product_change_number[23:16] <= wr_data;
                3'h4:    product_change_number[15:8]  <= wr_data;
                default: product_change_number[7:0]   <= wr_data;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request handshake for product change, teach, trigger, gated trigger
    cpi_req_ack #(
        .N (CPI_NREQ)
    ) u_req_ack (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .en       (ctrl_img_en),
        .req      (control_request_word[3:0]),
        .done     (act_done),
        .start    (act_start),
        .ack      (ack_lv)
    );

    // Error code and error flags captured when any action completes;
    // a later completion overwrites, so software reads the latest outcome
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            return_error_code <= CPI_RST_W32;
            err_bits          <= 3'h0;
        end else if (!ctrl_img_en) begin
            return_error_code <= CPI_RST_W32;
            err_bits          <= 3'h0;
        end else if (|act_done) begin
            return_error_code <= act_err_code;
            err_bits          <= act_err_flags;
        end
    end

    // Acknowledge word: bits 0-3 handshake, 13-15 teach, system, execution errors
    always_comb begin
        control_ack_word                          = CPI_RST_W16;
        control_ack_word[CPI_NREQ-1:0]            = ack_lv;
        control_ack_word[CPI_ACK_TEACHE +: 3]     = err_bits;
    end

    ////////////////////////////////////////////////////////////////////////
    // Inspection status word, refreshed every cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            inspection_status_word <= CPI_RST_W16;
        end else begin
            inspection_status_word                   <= CPI_RST_W16;
            inspection_status_word[CPI_ST_READY]     <= insp.ready;
            inspection_status_word[CPI_ST_PASS]      <= insp.pass;
            inspection_status_word[CPI_ST_READ]      <= insp.read_ok;
            inspection_status_word[CPI_ST_LATCH]     <= insp.ready_latch;
            inspection_status_word[CPI_ST_OUT1 +: 3] <= insp.outs;
            inspection_status_word[CPI_ST_MISSED]    <= insp.missed_flag;
        end
    end

    // Counters wrap at 32 bits; the sensor result and time are held from
    // the last completed inspection so the image stays coherent
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 7; i++) begin
                insp_word[i] <= CPI_RST_W32;
            end
        end else begin
            if (insp.done) begin
                insp_word[0] <= insp_word[0] + 32'h1;
                insp_word[1] <= insp.sensor_pf;
                insp_word[2] <= insp_word[2] + 32'h1;
                if (insp.pass) begin
                    insp_word[3] <= insp_word[3] + 32'h1;
                end else begin
                    insp_word[4] <= insp_word[4] + 32'h1;
                end
                insp_word[6] <= insp.insp_time;
            end
            if (insp.missed) begin
                insp_word[5] <= insp_word[5] + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Barcode header and records loaded by the decoder
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bc_hdr_q <= '0;
            for (int r = 0; r < CPI_MB_NREC; r++) begin
                bc_rec_q[r] <= '0;
            end
        end else begin
            if (bc_hdr_wr) begin
                bc_hdr_q <= bc_hdr;
            end
            if (bc_rec_wr && (32'(bc_rec_idx) < CPI_MB_NREC)) begin
                bc_rec_q[bc_rec_idx] <= bc_rec;
            end
        end
    end

    // String store is plain memory with no reset; contents before the
    // first load are undefined, so the decoder fills it before publishing
    always_ff @(posedge core_clk) begin
        if (bc_str_wr) begin
            str_mem[bc_str_addr] <= bc_str_data;
        end
    end

endmodule

`default_nettype wire

// >>> tb/cpi_bank_props.sv
// Checker: answer timing and refusals of the image bank ports.
// Assumes a bind onto cpi_bank; sees only its ports.
`default_nettype none
module cpi_bank_props
    import cpi_pkg::*;
(
    // Clock, reset and configuration
    input wire logic       core_clk, rst_b, ctrl_img_en,
    // Controller and action ports
    input wire logic       rd_req, rd_valid, rd_err, wr_req, wr_ack, wr_err,
    input wire cpi_at_s    rd_at, wr_at,
    input wire logic [7:0] rd_data,
    input wire logic [3:0] act_start
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // One answer per request, exactly one cycle later
    rd_ans_a: assert property (rd_valid == $past(rd_req)) else $error("read answer");
    wr_ans_a: assert property ((wr_ack | wr_err) == $past(wr_req)) else $error("write answer");
    wr_one_a: assert property (!(wr_ack && wr_err)) else $error("ack with err");
    err_zero_a: assert property (rd_err |-> rd_data == 8'h00) else $error("refused data");
    // Refusals by image and presence, then start pulse width; a missing image must never answer data
    bc_ro_a: assert property (wr_req && wr_at.slot == CPI_SLOT_SENS |=> wr_err) else $error("bc write");
    ctrl_rd_a: assert property (rd_req && rd_at[14:10] == {CPI_SLOT_CTRL, CPI_SUB_2} && !ctrl_img_en
        |=> rd_err) else $error("ctrl read");
    ctrl_wr_a: assert property (wr_req && wr_at.slot == CPI_SLOT_CTRL && !ctrl_img_en
        |=> wr_err) else $error("ctrl write");
    insp_on_a: assert property (rd_req && rd_at[14:10] == {CPI_SLOT_CTRL, CPI_SUB_1}
        |=> rd_err == ($past(rd_at.offs) >= CPI_INSP_LEN)) else $error("insp read");
    cmd_sub_a: assert property (rd_req && rd_at[14:10] == {CPI_SLOT_CMDCH, CPI_SUB_1} |=> rd_err) else $error("cmd rd");
    start_one_a: assert property ((act_start & $past(act_start)) == 4'h0) else $error("start width");
    cover property (rd_req ##1 rd_err);
    cover property (act_start != 4'h0);
    cover property (wr_req ##1 wr_ack);
endmodule
`default_nettype wire

// >>> tb/cpi_app_model.sv
// Stand-in application: finishes each started action after a delay.
// Assumes act_start pulses one cycle per request bit.
`default_nettype none
module cpi_app_model #(
    parameter int unsigned DLY = 3
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       slow,
    input  wire logic [3:0] act_start,
    output var  logic [3:0] act_done
);
    logic [4*DLY-1:0] dly_line;
    // Completion one cycle after start, or DLY cycles when slow
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) dly_line <= '0;
        else dly_line <= {dly_line[4*DLY-5:0], act_start};
    end
    assign act_done = slow ? dly_line[4*DLY-1 -: 4] : dly_line[3:0];
endmodule
`default_nettype wire

// >>> tb/test_cyclic_process_image_bank.sv
// Bench: drives the controller ports and the application side of the bank.
// Assumes the bank, its checker and the action stand-in are compiled first.
`default_nettype none
module test_cyclic_process_image_bank;
    timeunit 1ns;
    timeprecision 100ps;
    import cpi_pkg::*;
    logic core_clk = '0, rst_b = '0, ctrl_img_en = '1, rd_req = '0, wr_req = '0, slow = '0, rd_valid, rd_err;
    logic wr_ack, wr_err, bc_hdr_wr = '0, bc_rec_wr = '0, bc_str_wr = '0;
    logic [7:0] rd_data, wr_data = '0, bc_str_data = '0;
    logic [3:0] act_start, act_done, bc_rec_idx = '0;
    logic [31:0] act_err_code = 32'hcafe_0001, product_change_number;
    logic [2:0] act_err_flags = 3'h1;
    logic [8:0] bc_str_addr = '0;
    cpi_bc_e bc_sel = CPI_BC_NONE;
    cpi_cc_e cmd_cap = CPI_CC_0, rsp_cap = CPI_CC_0;
    cpi_at_s rd_at = '0, wr_at = '0;
    cpi_insp_s insp = '0;
    cpi_bc_hdr_s bc_hdr = '0;
    cpi_bc_rec_s bc_rec = '0;
    int fails = 0, n_compared = 0, cyc = 0;
    cpi_bank u_dut (.*);
    cpi_app_model u_app (.core_clk, .rst_b, .slow, .act_start, .act_done);
    // 4 ns clock and a cycle ceiling against hangs
    initial forever #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (++cyc > 20000) begin
        fails++;
        test_done();
    end
    ////////////////////////////////////////
    task automatic test_done();
        if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One byte access, judged one cycle after the request edge
    task automatic acc(logic w, logic [2:0] s, logic [1:0] u, logic [9:0] o, logic [7:0] d, logic e);
        tick(1);
        {rd_at, wr_at, wr_data} = {s, u, o, s, u, o, d};
        {wr_req, rd_req} = {w, !w};
        tick(1);
        {wr_req, rd_req} = 2'h0;
        chk(w ? "wr_err" : "rd_err", e, w ? wr_err : rd_err);
        chk(w ? "wr_ack" : "rd_valid", w ? !e : 1'b1, w ? wr_ack : rd_valid);
        if (!w) chk("rd_data", d, rd_data);
    endtask
    task automatic rd32(logic [2:0] s, logic [1:0] u, logic [9:0] o, logic [31:0] d);
        for (int i = 0; i < 4; i++) acc(0, s, u, o + 10'(i), d[31 - 8 * i -: 8], 0);
    endtask
    // One failed inspection and one missed trigger under fixed levels
    task automatic s_insp();
        insp = {8'hbb, 2'h3, 32'h1122_3344, 32'h0000_0099};
        tick(1);
        insp = {8'hbb, 2'h0, 32'h1122_3344, 32'h0000_0099};
        acc(0, 1, 1, 10'h001, 8'hdd, 0);
        rd32(1, 1, 10'h002, 32'h1);
        rd32(1, 1, 10'h006, 32'h1122_3344);
        rd32(1, 1, 10'h00e, 32'h0);
        rd32(1, 1, 10'h012, 32'h1);
        rd32(1, 1, 10'h016, 32'h1);
        rd32(1, 1, 10'h01a, 32'h99);
        acc(0, 1, 1, 10'h01e, 8'h00, 1);
        // A passing inspection moves the pass count and iteration count
        insp = {8'hfb, 2'h2, 64'h0};
        tick(1);
        insp = {8'hbb, 2'h0, 64'h0};
        rd32(1, 1, 10'h00a, 32'h2);
        rd32(1, 1, 10'h00e, 32'h1);
    endtask
    // Each request bit, alternately prompt and slow (bits 1 and 3 slow); then the change number and removal
    task automatic s_ctrl();
        logic [31:0] v = 32'h8421_00c3;
        for (int i = 0; i < 4; i++) begin
            slow = i[0];
            acc(1, 1, 2, 10'h001, 8'h01 << i, 0);
            tick(8);
            acc(0, 1, 2, 10'h001, 8'h01 << i, 0);
            acc(0, 1, 2, 10'h000, 8'h20, 0);
            acc(1, 1, 2, 10'h001, 8'h00, 0);
            tick(2);
            acc(0, 1, 2, 10'h001, 8'h00, 0);
        end
        rd32(1, 2, 10'h002, 32'hcafe_0001);
        for (int i = 0; i < 4; i++) acc(1, 1, 2, 10'(2 + i), v[31 - 8 * i -: 8], 0);
        chk("pcn", v, product_change_number);
        ctrl_img_en = 0;
        acc(0, 1, 2, 10'h000, 8'h00, 1);
        acc(1, 1, 2, 10'h001, 8'h01, 1);
        acc(0, 1, 1, 10'h001, 8'hdd, 0);
        ctrl_img_en = 1;
        acc(0, 1, 2, 10'h005, 8'h00, 0);
    endtask
    // Every single-image size at its string end, then the ten-record image
    task automatic s_bc();
        int e;
        bc_hdr = {32'h0000_0005, 32'h0};
        bc_rec = {16'h0, 32'h0000_0007, 32'h0};
        {bc_hdr_wr, bc_rec_wr} = 2'h3;
        tick(1);
        {bc_hdr_wr, bc_rec_wr} = 2'h0;
        for (int k = 1; k < 8; k++) begin
            bc_sel = cpi_bc_e'(k);
            bc_str_addr = (k < 7) ? 9'((8 << k) - 1) : 9'h13f;
            e = (k < 7) ? ((k == 1) ? 18 : 16) + (8 << k) : 408;
            {bc_str_data, bc_str_wr} = {8'(k), 1'b1};
            tick(1);
            bc_str_wr = 0;
            acc(0, 2, 1, 10'(e - 1), 8'(k), 0);
            acc(0, 2, 1, 10'(e), 8'h00, 1);
            if (k < 3 || k == 7) acc(0, 2, 1, (k == 1) ? 10'h00d : 10'h00b, 8'h07, 0);
        end
        acc(0, 2, 1, 10'h003, 8'h05, 0);
        acc(1, 2, 1, 10'h000, 8'h01, 1);
        bc_sel = CPI_BC_NONE;
        acc(0, 2, 1, 10'h000, 8'h00, 1);
    endtask
    // Command and response capacities in every size
    task automatic s_cmd();
        int c;
        for (int j = 0; j < 4; j++) begin
            cmd_cap = cpi_cc_e'(j);
            rsp_cap = cpi_cc_e'(j);
            c = (j == 0) ? 0 : 16 << j;
            if (j > 0) acc(1, 4, 1, 10'(c - 1), 8'h41, 0);
            if (j > 0) acc(0, 4, 2, 10'(c - 1), 8'h00, 0);
            acc(1, 4, 1, 10'(c), 8'h41, 1);
            acc(0, 4, 2, 10'(c), 8'h00, 1);
        end
        acc(0, 4, 1, 10'h000, 8'h00, 1);
    endtask
    initial begin
        tick(4);
        rst_b = 1;
        s_insp();
        s_ctrl();
        s_bc();
        s_cmd();
        test_done();
    end
endmodule
bind cpi_bank cpi_bank_props u_props (.core_clk, .rst_b, .ctrl_img_en, .rd_req, .rd_valid, .rd_err, .wr_req,
    .wr_ack, .wr_err, .rd_at, .wr_at, .rd_data, .act_start);
`default_nettype wire
